// File: core/power_accum.sv
// measurement formatting, rolling means and energy accumulation
// Contract
// R1: shunt result kept as 12-bit value
// R2: default sense format is unsigned unipolar
// R3: bipolar sense results are two's complement
// R4: code 10b halves range per channel
// R5: rail weight doubles only in full bipolar
// R6: shunt weight doubles only in full bipolar
// R7: raw samples signed, formatted only when stored
// R8: means built from signed internal samples
// R9: internal means per cycle, copies on refresh
// R10: depth field resets to 001b, eight
// R11: depths 4 to 128 selectable
// R12: codes ascend from 4, spare codes 128
// R13: means valid after configured sample count
// R14: depth change clears and restarts averaging
// R15: single mean reads refused until valid
// R16: bulk mean reads never refused
// R17: power is 12x12 signed 24-bit product
// R18: each sample added into energy accumulator
// R19: energy bipolar if either channel bipolar
// R20: adaptive mode accumulates as 8192 sps
// R21: adaptive mode left-shifts slower samples
// R22: adaptive mode advances tally by scale
// R23: shift log2 of 8192 over rate
// R24: host should pick bipolar, eight samples
// R25: adaptive mode follows its control bit
// R26: source select power, shunt or rail
// R27: accumulator and tally saturate and hold
// R28: accumulation always uses signed values
`timescale 1ns/100ps
`default_nettype none

module rolling_mean (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic clr_i,
    input wire logic push_i,
    input wire logic [2:0] sel_i,
    input wire logic signed [accum_pkg::ADC_W-1:0] sample_i,
    // result
    output logic signed [accum_pkg::ADC_W-1:0] mean_o,
    output logic full_o
);
    logic signed [accum_pkg::ADC_W-1:0] mem [2**accum_pkg::PTR_W];
    logic [accum_pkg::PTR_W-1:0] wr_q;
    logic [accum_pkg::CNT_W-1:0] cnt_q;
    logic signed [accum_pkg::SUM_W-1:0] sum_q;
    wire logic [accum_pkg::CNT_W-1:0] depth;
    wire logic [accum_pkg::PTR_W-1:0] old_idx;
    wire logic signed [accum_pkg::SUM_W-1:0] drop;
    wire logic signed [accum_pkg::SUM_W-1:0] sum_d;
    wire logic [2:0] shift;

    assign depth = accum_pkg::AVG_MIN_DEPTH << sel_i; // R11
    assign old_idx = wr_q - depth[accum_pkg::PTR_W-1:0];
    assign full_o = cnt_q >= depth; // R13
    assign drop = full_o ? accum_pkg::SUM_W'(mem[old_idx]) : '0;
    assign sum_d = sum_q + accum_pkg::SUM_W'(sample_i) - drop; // R8
    assign shift = sel_i + accum_pkg::AVG_MIN_SHIFT;
    assign mean_o = accum_pkg::ADC_W'(sum_q >>> shift);

    // sample history, no reset needed
    always_ff @(posedge clk_i)
    begin
        if (push_i)
        begin
            mem[wr_q] <= sample_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_q <= '0;
            cnt_q <= '0;
            sum_q <= '0;
        end
        else if (clr_i)
        begin
            cnt_q <= '0; // R14
            sum_q <= '0;
        end
        else if (push_i)
        begin
            wr_q <= wr_q + 1'b1;
            sum_q <= sum_d;
            cnt_q <= cnt_q + accum_pkg::CNT_W'(!full_o);
        end
    end
endmodule

module power_accum (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESETN_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [accum_pkg::ADDR_W-1:0] PADDR_I,
    input wire logic [accum_pkg::DATA_W-1:0] PWDATA_I,
    output logic [accum_pkg::DATA_W-1:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // converter link
    input wire logic CONV_CLK_I,
    input wire logic [accum_pkg::ADC_W-1:0] RAIL_RAW_I,
    input wire logic [accum_pkg::ADC_W-1:0] SHUNT_RAW_I,
    input wire logic LOW_RATE_I
);
    logic [2:0] clk_sync_q;
    logic [1:0] low_sync_q;
    logic signed [accum_pkg::ADC_W-1:0] rail_s1_q, rail_s2_q;
    logic signed [accum_pkg::ADC_W-1:0] shunt_s1_q, shunt_s2_q;
    logic [2:0] avg_code_q, rate_q;
    logic adaptive_scaling_enable_q, bulk_q;
    logic [1:0] src_q, rail_range_select_q, shunt_range_select_q;
    logic signed [accum_pkg::ADC_W-1:0] rail_last_q, shunt_last_q;
    logic signed [accum_pkg::PWR_W-1:0] power_product_q;
    logic [accum_pkg::ACC_W-1:0] energy_accumulator_q;
    logic [accum_pkg::TALLY_W-1:0] sample_tally_q;
    logic [accum_pkg::ADC_W-1:0] rail_rd_q, shunt_rd_q, rmean_rd_q, smean_rd_q;
    logic [accum_pkg::PWR_W-1:0] pwr_rd_q;
    logic [accum_pkg::ACC_W-1:0] acc_rd_q;
    logic [accum_pkg::TALLY_W-1:0] tally_rd_q;
    logic [accum_pkg::DATA_W-1:0] prdata_q;
    logic pready_q, pslverr_q;

    wire logic conv_evt, setup, wr_ok, avg_clr, refresh, acc_clr;
    wire logic sel_ctrl, sel_range, sel_cmd, sel_rail, sel_shunt, sel_rmean;
    wire logic sel_smean, sel_pwr, sel_alo, sel_ahi, sel_tally, sel_stat;
    wire logic is_mean, mapped, avg_valid, smean_full, energy_bipolar, pslverr_d;
    wire logic [2:0] avg_new, avg_sel, eff_rate;
    wire logic [3:0] shift;
    wire logic signed [accum_pkg::ADC_W-1:0] rail_mean, shunt_mean;
    wire logic signed [accum_pkg::PWR_W-1:0] pwr_now;
    wire logic signed [accum_pkg::ACC_W-1:0] acc_pick, acc_inc;
    wire logic [accum_pkg::ACC_W:0] acc_sum;
    wire logic [accum_pkg::ACC_W-1:0] acc_d;
    wire logic acc_hold;
    wire logic [accum_pkg::TALLY_W:0] tally_sum;
    wire logic [accum_pkg::TALLY_W-1:0] tally_d;
    wire logic [accum_pkg::DATA_W-1:0] ctrl_word, rdata_d;

    // signed raw sample to stored register form
    function automatic logic [11:0] fmt(input logic signed [11:0] v, input logic [1:0] rng);
        logic [11:0] r;
        r = v;
        case (rng)
            accum_pkg::RNG_UNI: r = v[11] ? '0 : 12'(v <<< 1); // R2 R5 R6
            accum_pkg::RNG_HALF: // R4
                if (v > accum_pkg::HALF_POS_LIM)
                    r = accum_pkg::POS_MAX;
                else if (v < accum_pkg::HALF_NEG_LIM)
                    r = accum_pkg::NEG_MIN;
                else
                    r = 12'(v <<< 1);
            default: r = v; // R3
        endcase
        return r;
    endfunction

    // active rate to adaptive shift
    function automatic logic [3:0] rate_shift(input logic [2:0] rate);
        logic [3:0] s;
        case (rate)
            accum_pkg::RATE_4096: s = accum_pkg::SHIFT_4096;
            accum_pkg::RATE_1024: s = accum_pkg::SHIFT_1024;
            accum_pkg::RATE_256: s = accum_pkg::SHIFT_256;
            accum_pkg::RATE_64: s = accum_pkg::SHIFT_64;
            accum_pkg::RATE_8: s = accum_pkg::SHIFT_8;
            default: s = '0;
        endcase
        return s;
    endfunction

    // link edge detect and apb decode
    assign conv_evt = clk_sync_q[1] & ~clk_sync_q[2];
    assign setup = PSEL_I & ~PENABLE_I;
    assign wr_ok = PSEL_I & PENABLE_I & PWRITE_I & pready_q & ~pslverr_q;
    assign sel_ctrl = PADDR_I == accum_pkg::OFF_CTRL;
    assign sel_range = PADDR_I == accum_pkg::OFF_RANGE;
    assign sel_cmd = PADDR_I == accum_pkg::OFF_CMD;
    assign sel_rail = PADDR_I == accum_pkg::OFF_RAIL;
    assign sel_shunt = PADDR_I == accum_pkg::OFF_SHUNT;
    assign sel_rmean = PADDR_I == accum_pkg::OFF_RAIL_MEAN;
    assign sel_smean = PADDR_I == accum_pkg::OFF_SHUNT_MEAN;
    assign sel_pwr = PADDR_I == accum_pkg::OFF_POWER;
    assign sel_alo = PADDR_I == accum_pkg::OFF_ACC_LO;
    assign sel_ahi = PADDR_I == accum_pkg::OFF_ACC_HI;
    assign sel_tally = PADDR_I == accum_pkg::OFF_TALLY;
    assign sel_stat = PADDR_I == accum_pkg::OFF_STATUS;
    assign is_mean = sel_rmean | sel_smean;
    assign mapped = sel_ctrl | sel_range | sel_cmd | sel_rail | sel_shunt | is_mean
        | sel_pwr | sel_alo | sel_ahi | sel_tally | sel_stat;
    assign pslverr_d = ~mapped | (~PWRITE_I & is_mean & ~avg_valid & ~bulk_q); // R15 R16
    assign avg_new = PWDATA_I[accum_pkg::CTRL_AVG_LSB +: 3];
    assign avg_clr = wr_ok & sel_ctrl & (avg_new != avg_code_q); // R14
    assign refresh = wr_ok & sel_cmd & PWDATA_I[accum_pkg::CMD_REFRESH];
    assign acc_clr = wr_ok & sel_cmd & PWDATA_I[accum_pkg::CMD_CLEAR];
    assign avg_sel = (avg_code_q > accum_pkg::AVG_MAX) ? accum_pkg::AVG_MAX : avg_code_q; // R12
    assign avg_valid = smean_full;

    // power and accumulation datapath
    assign pwr_now = rail_s2_q * shunt_s2_q; // R17 R28
    assign eff_rate = low_sync_q[1] ? accum_pkg::RATE_8 : rate_q;
    assign shift = adaptive_scaling_enable_q ? rate_shift(eff_rate) : '0; // R20 R23 R25
    assign acc_pick = (src_q == accum_pkg::SRC_SHUNT) ? accum_pkg::ACC_W'(shunt_s2_q)
        : (src_q == accum_pkg::SRC_RAIL) ? accum_pkg::ACC_W'(rail_s2_q)
        : accum_pkg::ACC_W'(pwr_now); // R26
    assign acc_inc = acc_pick <<< shift; // R21
    assign acc_sum = {energy_accumulator_q[accum_pkg::ACC_W-1], energy_accumulator_q}
        + {acc_inc[accum_pkg::ACC_W-1], acc_inc}; // R18
    assign acc_d = (acc_sum[accum_pkg::ACC_W] != acc_sum[accum_pkg::ACC_W-1])
        ? (acc_sum[accum_pkg::ACC_W] ? accum_pkg::ACC_MIN : accum_pkg::ACC_MAX)
        : acc_sum[accum_pkg::ACC_W-1:0]; // R27
    assign acc_hold = (energy_accumulator_q == accum_pkg::ACC_MAX)
        | (energy_accumulator_q == accum_pkg::ACC_MIN);
    assign tally_sum = {1'b0, sample_tally_q} + (33'h1 << shift); // R22
    assign tally_d = tally_sum[accum_pkg::TALLY_W] ? '1 : tally_sum[accum_pkg::TALLY_W-1:0];
    assign energy_bipolar = (rail_range_select_q != accum_pkg::RNG_UNI)
        | (shunt_range_select_q != accum_pkg::RNG_UNI); // R19

    // read mux
    assign ctrl_word = {21'h0, rate_q, 1'b0, bulk_q, src_q, adaptive_scaling_enable_q, avg_code_q};
    assign rdata_d = sel_ctrl ? ctrl_word
        : sel_range ? {28'h0, shunt_range_select_q, rail_range_select_q}
        : sel_rail ? {20'h0, rail_rd_q}
        : sel_shunt ? {20'h0, shunt_rd_q}
        : sel_rmean ? {20'h0, rmean_rd_q}
        : sel_smean ? {20'h0, smean_rd_q}
        : sel_pwr ? {8'h0, pwr_rd_q}
        : sel_alo ? acc_rd_q[31:0]
        : sel_ahi ? {8'h0, acc_rd_q[55:32]}
        : sel_tally ? tally_rd_q
        : sel_stat ? {30'h0, energy_bipolar, avg_valid}
        : '0;

    rolling_mean u_rail_mean (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESETN_I),
        .clr_i(avg_clr),
        .push_i(conv_evt), // R9
        .sel_i(avg_sel),
        .sample_i(rail_s2_q),
        .mean_o(rail_mean),
        .full_o()
    );

    rolling_mean u_shunt_mean (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESETN_I),
        .clr_i(avg_clr),
        .push_i(conv_evt),
        .sel_i(avg_sel),
        .sample_i(shunt_s2_q),
        .mean_o(shunt_mean),
        .full_o(smean_full)
    );

    // synchronisers for the converter link
    always_ff @(posedge REF_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            clk_sync_q <= '0;
            low_sync_q <= '0;
            rail_s1_q <= '0;
            rail_s2_q <= '0;
            shunt_s1_q <= '0;
            shunt_s2_q <= '0;
        end
        else
        begin
            clk_sync_q <= {clk_sync_q[1:0], CONV_CLK_I};
            low_sync_q <= {low_sync_q[0], LOW_RATE_I};
            rail_s1_q <= RAIL_RAW_I;
            rail_s2_q <= rail_s1_q; // R7
            shunt_s1_q <= SHUNT_RAW_I;
            shunt_s2_q <= shunt_s1_q;
        end
    end

    // configuration registers
    always_ff @(posedge REF_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            avg_code_q <= accum_pkg::AVG_RESET; // R10
            rate_q <= accum_pkg::RATE_RESET;
            adaptive_scaling_enable_q <= 1'b0;
            bulk_q <= 1'b0;
            src_q <= accum_pkg::SRC_POWER;
            rail_range_select_q <= accum_pkg::RNG_UNI;
            shunt_range_select_q <= accum_pkg::RNG_UNI;
        end
        else if (wr_ok & sel_ctrl)
        begin
            avg_code_q <= avg_new;
            adaptive_scaling_enable_q <= PWDATA_I[accum_pkg::CTRL_AA]; // R25
            src_q <= PWDATA_I[accum_pkg::CTRL_SRC_LSB +: 2];
            bulk_q <= PWDATA_I[accum_pkg::CTRL_BULK];
            rate_q <= PWDATA_I[accum_pkg::CTRL_RATE_LSB +: 3];
        end
        else if (wr_ok & sel_range)
        begin
            rail_range_select_q <= PWDATA_I[accum_pkg::RANGE_RAIL_LSB +: 2];
            shunt_range_select_q <= PWDATA_I[accum_pkg::RANGE_SHUNT_LSB +: 2];
        end
    end

    // per-sample state and accumulator
    always_ff @(posedge REF_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            rail_last_q <= '0;
            shunt_last_q <= '0;
            power_product_q <= '0;
            energy_accumulator_q <= '0;
            sample_tally_q <= '0;
        end
        else
        begin
            if (conv_evt)
            begin
                rail_last_q <= rail_s2_q;
                shunt_last_q <= shunt_s2_q;
                power_product_q <= pwr_now; // R17
            end
            if (acc_clr)
            begin
                energy_accumulator_q <= '0;
                sample_tally_q <= '0;
            end
            else if (conv_evt)
            begin
                energy_accumulator_q <= acc_hold ? energy_accumulator_q : acc_d; // R27
                sample_tally_q <= tally_d; // R22
            end
        end
    end

    // host-visible copies, refreshed on command only
    always_ff @(posedge REF_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            rail_rd_q <= '0;
            shunt_rd_q <= '0;
            rmean_rd_q <= '0;
            smean_rd_q <= '0;
            pwr_rd_q <= '0;
            acc_rd_q <= '0;
            tally_rd_q <= '0;
        end
        else if (refresh)
        begin
            rail_rd_q <= fmt(rail_last_q, rail_range_select_q); // R9
            shunt_rd_q <= fmt(shunt_last_q, shunt_range_select_q); // R1
            rmean_rd_q <= fmt(rail_mean, rail_range_select_q);
            smean_rd_q <= fmt(shunt_mean, shunt_range_select_q);
            pwr_rd_q <= power_product_q;
            acc_rd_q <= energy_accumulator_q;
            tally_rd_q <= sample_tally_q;
        end
    end

    // apb answer, one wait-free access phase
    always_ff @(posedge REF_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup & pslverr_d; // R15
            prdata_q <= (setup & ~PWRITE_I & ~pslverr_d) ? rdata_d : '0;
        end
    end

    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    sequence s_mean_read;
        setup && !PWRITE_I && is_mean;
    endsequence

    a_depth_reset: assert property ($rose(RESETN_I) |-> avg_code_q == accum_pkg::AVG_RESET) // R10
        else $error("depth field not at reset code");
    a_mean_nack: assert property (s_mean_read ##0 (!avg_valid && !bulk_q) |=> PREADY_O && PSLVERR_O) // R15
        else $error("early mean read not refused");
    a_bulk_no_nack: assert property (s_mean_read ##0 bulk_q |=> PREADY_O && !PSLVERR_O) // R16
        else $error("bulk mean read refused");
    a_copy_stable: assert property (!refresh |=> $stable(rail_rd_q) && $stable(smean_rd_q)) // R9
        else $error("readable copy changed without refresh");
    a_power_prod: assert property (conv_evt |=> power_product_q == $past(rail_s2_q) * $past(shunt_s2_q)) // R17
        else $error("power product mismatch");
    a_tally_step: assert property (conv_evt && !acc_clr && !tally_sum[accum_pkg::TALLY_W]
        |=> sample_tally_q == $past(sample_tally_q) + (32'h1 << $past(shift))) // R22
        else $error("tally step wrong");
    a_acc_hold: assert property (energy_accumulator_q == accum_pkg::ACC_MAX && !acc_clr
        |=> energy_accumulator_q == accum_pkg::ACC_MAX) // R27
        else $error("saturated accumulator moved");
    a_depth_restart: assert property (avg_clr |=> !avg_valid [*2]) // R14
        else $error("means valid right after depth change");
    a_valid_cause: assert property ($rose(avg_valid) |-> $past(conv_evt)) // R13
        else $error("means valid without a new sample");
    a_shift_slow: assert property (adaptive_scaling_enable_q && low_sync_q[1]
        |-> shift == accum_pkg::SHIFT_8) // R21
        else $error("slow rate shift wrong");
endmodule

`default_nettype wire

// File: core/accum_pkg.sv
// constants for the measurement and accumulation path
package accum_pkg;
    localparam int ADC_W = 12;
    localparam int PWR_W = 24;
    localparam int ACC_W = 56;
    localparam int TALLY_W = 32;
    localparam int SUM_W = 19;
    localparam int PTR_W = 7;
    localparam int CNT_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RANGE = 8'h04;
    localparam logic [7:0] OFF_CMD = 8'h08;
    localparam logic [7:0] OFF_RAIL = 8'h0c;
    localparam logic [7:0] OFF_SHUNT = 8'h10;
    localparam logic [7:0] OFF_RAIL_MEAN = 8'h14;
    localparam logic [7:0] OFF_SHUNT_MEAN = 8'h18;
    localparam logic [7:0] OFF_POWER = 8'h1c;
    localparam logic [7:0] OFF_ACC_LO = 8'h20;
    localparam logic [7:0] OFF_ACC_HI = 8'h24;
    localparam logic [7:0] OFF_TALLY = 8'h28;
    localparam logic [7:0] OFF_STATUS = 8'h2c;
    // field positions
    localparam int CTRL_AVG_LSB = 0;
    localparam int CTRL_AA = 3;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_BULK = 6;
    localparam int CTRL_RATE_LSB = 8;
    localparam int RANGE_RAIL_LSB = 0;
    localparam int RANGE_SHUNT_LSB = 2;
    localparam int CMD_REFRESH = 0;
    localparam int CMD_CLEAR = 1;
    // reset values and codes
    localparam logic [2:0] AVG_RESET = 3'h1;
    localparam logic [2:0] AVG_MAX = 3'h5;
    localparam logic [7:0] AVG_MIN_DEPTH = 8'h04;
    localparam logic [2:0] AVG_MIN_SHIFT = 3'h2;
    localparam logic [2:0] RATE_RESET = 3'h2;
    localparam logic [1:0] RNG_UNI = 2'h0;
    localparam logic [1:0] RNG_BIP = 2'h1;
    localparam logic [1:0] RNG_HALF = 2'h2;
    localparam logic [1:0] SRC_POWER = 2'h0;
    localparam logic [1:0] SRC_SHUNT = 2'h1;
    localparam logic [1:0] SRC_RAIL = 2'h2;
    localparam logic [2:0] RATE_8192 = 3'h0;
    localparam logic [2:0] RATE_4096 = 3'h1;
    localparam logic [2:0] RATE_1024 = 3'h2;
    localparam logic [2:0] RATE_256 = 3'h3;
    localparam logic [2:0] RATE_64 = 3'h4;
    localparam logic [2:0] RATE_8 = 3'h5;
    localparam logic [3:0] SHIFT_4096 = 4'h1;
    localparam logic [3:0] SHIFT_1024 = 4'h3;
    localparam logic [3:0] SHIFT_256 = 4'h5;
    localparam logic [3:0] SHIFT_64 = 4'h7;
    localparam logic [3:0] SHIFT_8 = 4'ha;
    localparam logic signed [11:0] HALF_POS_LIM = 12'sh3ff;
    localparam logic signed [11:0] HALF_NEG_LIM = 12'shc00;
    localparam logic [11:0] POS_MAX = 12'h7ff;
    localparam logic [11:0] NEG_MIN = 12'h800;
    localparam logic [55:0] ACC_MAX = 56'h7f_ffff_ffff_ffff;
    localparam logic [55:0] ACC_MIN = 56'h80_0000_0000_0000;
endpackage

// File: verif/conv_link_model.sv
// converter link model: link clock and raw samples
`timescale 1ns/100ps
`default_nettype none

module conv_link_model (
    // clock
    input wire logic ref_clk_i,
    // link outputs
    output logic conv_clk_o,
    output logic [accum_pkg::ADC_W-1:0] rail_raw_o,
    output logic [accum_pkg::ADC_W-1:0] shunt_raw_o
);
    initial
    begin
        conv_clk_o = 1'b0;
        rail_raw_o = 12'h000;
        shunt_raw_o = 12'h000;
    end

    // one frame: data set, link clock rises, held, then released
    task automatic frame(input logic [11:0] r, input logic [11:0] s);
        @(posedge ref_clk_i);
        rail_raw_o <= r;
        shunt_raw_o <= s;
        repeat (4) @(posedge ref_clk_i);
        conv_clk_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        conv_clk_o <= 1'b0;
        rail_raw_o <= ~r;
        shunt_raw_o <= ~s;
    endtask
endmodule

`default_nettype wire

// File: verif/power_accum_tb.sv
// self-checking bench for the measurement and accumulation path
`timescale 1ns/100ps
`default_nettype none

module power_accum_tb;
    logic clk;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic low_rate;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic conv_clk;
    logic [11:0] rail_raw;
    logic [11:0] shunt_raw;
    logic [31:0] rdata;
    logic rerr;
    int miscompares = 0;
    int samples_checked = 0;

    power_accum dut (
        .REF_CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .CONV_CLK_I(conv_clk),
        .RAIL_RAW_I(rail_raw), .SHUNT_RAW_I(shunt_raw), .LOW_RATE_I(low_rate)
    );

    conv_link_model link (.ref_clk_i(clk), .conv_clk_o(conv_clk), .rail_raw_o(rail_raw), .shunt_raw_o(shunt_raw));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // apb transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1);
        chk("access cycles", 32'd1, 32'(n));
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk, input logic experr);
        xfer(1'b0, a, 32'h0);
        chk($sformatf("data at %h", a), exp & msk, rdata & msk);
        chk($sformatf("error at %h", a), {31'h0, experr}, {31'h0, rerr});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        chk($sformatf("write error at %h", a), 32'h0, {31'h0, rerr});
    endtask

    task automatic conv(input logic [11:0] r, input logic [11:0] s);
        link.frame(r, s);
        repeat (4) @(posedge clk);
    endtask

    task automatic s_reset_map;
        rd(accum_pkg::OFF_CTRL, 32'h0000_0201, 32'h0000_07ff, 1'b0);
        rd(accum_pkg::OFF_RANGE, 32'h0, 32'h0000_000f, 1'b0);
        rd(8'h30, 32'h0, 32'hffff_ffff, 1'b1);
        rd(accum_pkg::OFF_RAIL_MEAN, 32'h0, 32'hffff_ffff, 1'b1);
    endtask

    task automatic s_format;
        conv(12'h064, 12'hff8);
        wr(accum_pkg::OFF_CMD, 32'h1);
        rd(accum_pkg::OFF_RAIL, 32'h0c8, 32'hfff, 1'b0);
        rd(accum_pkg::OFF_SHUNT, 32'h000, 32'hfff, 1'b0);
        rd(accum_pkg::OFF_POWER, 32'hfffce0, 32'hffffff, 1'b0);
        rd(accum_pkg::OFF_ACC_LO, 32'hfffffce0, 32'hffffffff, 1'b0);
        rd(accum_pkg::OFF_ACC_HI, 32'hffffff, 32'hffffff, 1'b0);
        rd(accum_pkg::OFF_TALLY, 32'h1, 32'hffffffff, 1'b0);
        wr(accum_pkg::OFF_RANGE, 32'h6);
        conv(12'h500, 12'hff8);
        wr(accum_pkg::OFF_CMD, 32'h1);
        rd(accum_pkg::OFF_RAIL, 32'h7ff, 32'hfff, 1'b0);
        rd(accum_pkg::OFF_SHUNT, 32'hff8, 32'hfff, 1'b0);
        rd(accum_pkg::OFF_STATUS, 32'h2, 32'h2, 1'b0);
    endtask

    task automatic s_mean;
        wr(accum_pkg::OFF_RANGE, 32'h0);
        wr(accum_pkg::OFF_CTRL, 32'h200);
        conv(12'h064, 12'hff0);
        conv(12'h064, 12'hff0);
        conv(12'h064, 12'h010);
        rd(accum_pkg::OFF_STATUS, 32'h0, 32'h1, 1'b0);
        conv(12'h064, 12'h030);
        rd(accum_pkg::OFF_STATUS, 32'h1, 32'h1, 1'b0);
        wr(accum_pkg::OFF_CMD, 32'h1);
        rd(accum_pkg::OFF_SHUNT_MEAN, 32'h010, 32'hfff, 1'b0);
        rd(accum_pkg::OFF_RAIL_MEAN, 32'h0c8, 32'hfff, 1'b0);
        conv(12'h064, 12'h030);
        rd(accum_pkg::OFF_SHUNT_MEAN, 32'h010, 32'hfff, 1'b0);
        wr(accum_pkg::OFF_CTRL, 32'h201);
        rd(accum_pkg::OFF_STATUS, 32'h0, 32'h1, 1'b0);
        rd(accum_pkg::OFF_SHUNT_MEAN, 32'h0, 32'hffffffff, 1'b1);
        wr(accum_pkg::OFF_CTRL, 32'h241);
        rd(accum_pkg::OFF_RAIL_MEAN, 32'h0c8, 32'hfff, 1'b0);
        wr(accum_pkg::OFF_CTRL, 32'h006);
        repeat (127) conv(12'h064, 12'h020);
        rd(accum_pkg::OFF_STATUS, 32'h0, 32'h1, 1'b0);
        conv(12'h064, 12'h020);
        rd(accum_pkg::OFF_STATUS, 32'h1, 32'h1, 1'b0);
    endtask

    task automatic s_adapt;
        wr(accum_pkg::OFF_CTRL, 32'h508);
        wr(accum_pkg::OFF_CMD, 32'h2);
        conv(12'h001, 12'h001);
        wr(accum_pkg::OFF_CMD, 32'h1);
        rd(accum_pkg::OFF_ACC_LO, 32'd1024, 32'hffffffff, 1'b0);
        rd(accum_pkg::OFF_TALLY, 32'd1024, 32'hffffffff, 1'b0);
        wr(accum_pkg::OFF_CTRL, 32'h008);
        low_rate <= 1'b1;
        conv(12'h001, 12'h001);
        low_rate <= 1'b0;
        conv(12'h001, 12'h001);
        wr(accum_pkg::OFF_CTRL, 32'h500);
        conv(12'h001, 12'h001);
        wr(accum_pkg::OFF_CMD, 32'h1);
        rd(accum_pkg::OFF_ACC_LO, 32'd2050, 32'hffffffff, 1'b0);
        rd(accum_pkg::OFF_TALLY, 32'd2050, 32'hffffffff, 1'b0);
        for (int i = 1; i < 5; i++)
        begin
            wr(accum_pkg::OFF_CTRL, (32'(i) << 8) | 32'h8);
            wr(accum_pkg::OFF_CMD, 32'h2);
            conv(12'h001, 12'h001);
            wr(accum_pkg::OFF_CMD, 32'h1);
            rd(accum_pkg::OFF_TALLY, 32'd2 << (2 * i - 2), 32'hffffffff, 1'b0);
        end
    endtask

    task automatic s_source;
        for (int i = 0; i < 3; i++)
        begin
            wr(accum_pkg::OFF_CTRL, 32'(i) << 4);
            wr(accum_pkg::OFF_CMD, 32'h2);
            conv(12'h003, 12'h005);
            wr(accum_pkg::OFF_CMD, 32'h1);
            rd(accum_pkg::OFF_ACC_LO, (i == 0) ? 32'd15 : ((i == 1) ? 32'd5 : 32'd3), 32'hffffffff, 1'b0);
        end
    endtask

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        low_rate = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        s_reset_map();
        s_format();
        s_mean();
        s_adapt();
        s_source();
        end_of_test();
    end

    initial
    begin
        repeat (8000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
endmodule

`default_nettype wire
